/* File: hw/cse_exec_core.sv */
// Function
// RQ1 - Compares set Z N V C H, one cycle
// RQ2 - Register bit skip: 1, 2 or 3 cycles
// RQ3 - I/O bit skip: same timing, flags kept
// RQ4 - Status-bit branch: PC+k+1, 1/2 cycles
// RQ5 - Equal on Z one, not-equal on zero
// RQ6 - Unsigned ge on C zero, lt on one
// RQ7 - Signed ge on N^V zero, lt one
// RQ8 - Plus on N zero, minus on one
// RQ9 - Half-carry branches on H one/zero
// RQ10 - Transfer-flag branches on T one/zero
// RQ11 - Overflow branches on V one/zero
// RQ12 - Interrupt branches on I one/zero
// RQ13 - I/O bit set/clear, two cycles, no flags
// RQ14 - Logical shifts fill zero, update flags
// RQ15 - Rotates move carry through, update flags
// RQ16 - Bit store to T, load from T
// RQ17 - Arithmetic right shift keeps bit 7
// RQ18 - Flag force touches only named flag
`timescale 1ns/1ps
`include "cse_map.svh"

module cse_exec_core (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  cse_pkg::cse_state_e state_reg, state_next;
  cse_pkg::cse_cmd_s cmd_reg, cmd_next, cmd_new;
  cse_pkg::cse_alu_out_s alu_out;
  logic [1:0] cnt_reg, cnt_next, cyc_reg, cyc_next;
  logic [7:0] opa_reg, opa_next, opb_reg, opb_next;
  logic [7:0] flags_reg, flags_next, io_reg, io_next;
  logic [15:0] pc_reg, pc_next;
  logic taken_reg, taken_next;
  logic [31:0] prdata_reg, prdata_next;
  logic err_reg, err_next;
  logic wr_go, commit, busy, cond_now, mapped;
  logic go_cmd, cond_now_new;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  cse_alu u_alu (
    .cmd(cmd_reg),
    .opa(opa_reg),
    .opb(opb_reg),
    .flags_in(flags_reg),
    .alu_out(alu_out)
  );

  // Skip or branch condition
  function automatic logic cond_of(input cse_pkg::cse_cmd_s c, input logic [7:0] f,
                                   input logic [7:0] a, input logic [7:0] io);
    case (c.op)
      cse_pkg::OP_SKIP_IF_REG_BIT_CLEAR: cond_of = ~a[c.sel]; // RQ2
      cse_pkg::OP_SKIP_IF_REG_BIT_SET: cond_of = a[c.sel]; // RQ2
      cse_pkg::OP_SKIP_IF_IO_BIT_CLEAR: cond_of = ~io[c.sel]; // RQ3
      cse_pkg::OP_SKIP_IF_IO_BIT_SET: cond_of = io[c.sel]; // RQ3
      cse_pkg::OP_BRANCH_STATUS_BIT_SET: cond_of = f[c.sel]; // RQ4
      cse_pkg::OP_BRANCH_STATUS_BIT_CLEAR: cond_of = ~f[c.sel]; // RQ4
      cse_pkg::OP_BRANCH_IF_EQUAL: cond_of = f[`CSE_F_Z]; // RQ5
      cse_pkg::OP_BRANCH_IF_NOT_EQUAL: cond_of = ~f[`CSE_F_Z]; // RQ5
      cse_pkg::OP_BRANCH_UNSIGNED_GE: cond_of = ~f[`CSE_F_C]; // RQ6
      cse_pkg::OP_BRANCH_UNSIGNED_LT: cond_of = f[`CSE_F_C]; // RQ6
      cse_pkg::OP_BRANCH_SIGNED_GE: cond_of = ~(f[`CSE_F_N] ^ f[`CSE_F_V]); // RQ7
      cse_pkg::OP_BRANCH_SIGNED_LT: cond_of = f[`CSE_F_N] ^ f[`CSE_F_V]; // RQ7
      cse_pkg::OP_BRANCH_IF_POSITIVE: cond_of = ~f[`CSE_F_N]; // RQ8
      cse_pkg::OP_BRANCH_IF_NEGATIVE: cond_of = f[`CSE_F_N]; // RQ8
      cse_pkg::OP_BRANCH_HALFCARRY_ONE: cond_of = f[`CSE_F_H]; // RQ9
      cse_pkg::OP_BRANCH_HALFCARRY_ZERO: cond_of = ~f[`CSE_F_H]; // RQ9
      cse_pkg::OP_BRANCH_TRANSFER_FLAG_ONE: cond_of = f[`CSE_F_T]; // RQ10
      cse_pkg::OP_BRANCH_TRANSFER_FLAG_ZERO: cond_of = ~f[`CSE_F_T]; // RQ10
      cse_pkg::OP_BRANCH_OVERFLOW_ONE: cond_of = f[`CSE_F_V]; // RQ11
      cse_pkg::OP_BRANCH_OVERFLOW_ZERO: cond_of = ~f[`CSE_F_V]; // RQ11
      cse_pkg::OP_BRANCH_IRQ_ON: cond_of = f[`CSE_F_I]; // RQ12
      cse_pkg::OP_BRANCH_IRQ_OFF: cond_of = ~f[`CSE_F_I]; // RQ12
      default: cond_of = 1'b0;
    endcase
  endfunction

  function automatic logic is_skip(input cse_pkg::cse_op_e op);
    is_skip = (op >= cse_pkg::OP_SKIP_IF_REG_BIT_CLEAR) &&
              (op <= cse_pkg::OP_SKIP_IF_IO_BIT_SET);
  endfunction

  function automatic logic is_branch(input cse_pkg::cse_op_e op);
    is_branch = (op >= cse_pkg::OP_BRANCH_STATUS_BIT_SET) &&
                (op <= cse_pkg::OP_BRANCH_IRQ_OFF);
  endfunction

  function automatic logic is_io_wr(input cse_pkg::cse_op_e op);
    is_io_wr = (op == cse_pkg::OP_IO_BIT_SET_OP) || (op == cse_pkg::OP_IO_BIT_CLEAR_OP);
  endfunction

  // Cycle count fixed when the command is taken
  function automatic logic [1:0] cycles_of(input cse_pkg::cse_cmd_s c, input logic cond);
    if (is_skip(c.op)) begin
      cycles_of = !cond ? `CSE_CYC_ONE : (c.two_word ? `CSE_CYC_THREE : `CSE_CYC_TWO); // RQ2 RQ3
    end else if (is_branch(c.op)) begin
      cycles_of = cond ? `CSE_CYC_TWO : `CSE_CYC_ONE; // RQ4
    end else if (is_io_wr(c.op)) begin
      cycles_of = `CSE_CYC_TWO; // RQ13
    end else begin
      cycles_of = `CSE_CYC_ONE; // RQ1 RQ14 RQ16 RQ18
    end
  endfunction

  assign busy = (state_reg == cse_pkg::ST_EXEC);
  assign commit = busy && (cnt_reg == `CSE_CYC_ONE);
  assign wr_go = psel && penable && pwrite && !err_reg;
  assign cmd_new = pwdata[`CSE_CMD_TWO_WORD:`CSE_CMD_OP_LSB];
  assign cond_now = cond_of(cmd_reg, flags_reg, opa_reg, io_reg);
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = err_reg;

  always_comb begin
    mapped = 1'b1;
    prdata_next = 32'h0000_0000;
    case (paddr)
      `CSE_OFS_CMD: prdata_next = {15'h0000, cmd_reg};
      `CSE_OFS_OPA: prdata_next = {24'h00_0000, opa_reg};
      `CSE_OFS_OPB: prdata_next = {24'h00_0000, opb_reg};
      `CSE_OFS_FLAGS: prdata_next = {24'h00_0000, flags_reg};
      `CSE_OFS_PC: prdata_next = {16'h0000, pc_reg};
      `CSE_OFS_IOREG: prdata_next = {24'h00_0000, io_reg};
      `CSE_OFS_STATUS: prdata_next = {28'h000_0000, cyc_reg, taken_reg, busy};
      default: mapped = 1'b0;
    endcase
    err_next = 1'b0;
    if (psel && !penable) begin
      // Writes refused while executing and on read-only status
      err_next = !mapped || (pwrite && (busy || paddr == `CSE_OFS_STATUS));
    end else begin
      prdata_next = prdata_reg;
      err_next = err_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cmd_next = cmd_reg;
    cyc_next = cyc_reg;
    opa_next = opa_reg;
    opb_next = opb_reg;
    flags_next = flags_reg;
    io_next = io_reg;
    pc_next = pc_reg;
    taken_next = taken_reg;
    if (wr_go) begin
      case (paddr)
        `CSE_OFS_CMD: begin
          cmd_next = cmd_new;
          state_next = cse_pkg::ST_EXEC;
          cnt_next = cycles_of(cmd_new, cond_of(cmd_new, flags_reg, opa_reg, io_reg));
          cyc_next = cnt_next;
        end
        `CSE_OFS_OPA: opa_next = pwdata[7:0];
        `CSE_OFS_OPB: opb_next = pwdata[7:0];
        `CSE_OFS_FLAGS: flags_next = pwdata[7:0];
        `CSE_OFS_PC: pc_next = pwdata[15:0];
        `CSE_OFS_IOREG: io_next = pwdata[7:0];
        default: cmd_next = cmd_reg;
      endcase
    end
    if (busy) begin
      cnt_next = cnt_reg - 2'd1;
    end
    if (commit) begin
      state_next = cse_pkg::ST_IDLE;
      flags_next = alu_out.flags;
      taken_next = cond_now;
      pc_next = pc_reg + 16'h0001;
      if (alu_out.wr_rd) begin
        opa_next = alu_out.res;
      end
      if (is_skip(cmd_reg.op) && cond_now) begin
        pc_next = pc_reg + (cmd_reg.two_word ? 16'h0003 : 16'h0002); // RQ2 RQ3
      end
      if (is_branch(cmd_reg.op) && cond_now) begin
        pc_next = pc_reg + {{9{cmd_reg.k[6]}}, cmd_reg.k} + 16'h0001; // RQ4
      end
      if (cmd_reg.op == cse_pkg::OP_IO_BIT_SET_OP) begin
        io_next[cmd_reg.sel] = 1'b1; // RQ13
      end
      if (cmd_reg.op == cse_pkg::OP_IO_BIT_CLEAR_OP) begin
        io_next[cmd_reg.sel] = 1'b0; // RQ13
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= cse_pkg::ST_IDLE;
      cnt_reg <= 2'd0;
      cyc_reg <= 2'd0;
      cmd_reg <= `CSE_RST_CMD;
      opa_reg <= `CSE_RST_BYTE;
      opb_reg <= `CSE_RST_BYTE;
      flags_reg <= `CSE_RST_BYTE;
      io_reg <= `CSE_RST_BYTE;
      pc_reg <= `CSE_RST_PC;
      taken_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cyc_reg <= cyc_next;
      cmd_reg <= cmd_next;
      opa_reg <= opa_next;
      opb_reg <= opb_next;
      flags_reg <= flags_next;
      io_reg <= io_next;
      pc_reg <= pc_next;
      taken_reg <= taken_next;
      prdata_reg <= prdata_next;
      err_reg <= err_next;
    end
  end

  assign go_cmd = wr_go && (paddr == `CSE_OFS_CMD);
  assign cond_now_new = cond_of(cmd_new, flags_reg, opa_reg, io_reg);

  sequence busy_then_idle_1;
    busy ##1 !busy;
  endsequence

  sequence busy_then_idle_2;
    busy [*2] ##1 !busy;
  endsequence

  AST_CMP_ONE_CYCLE: assert property ( // RQ1
    go_cmd && (cmd_new.op inside {cse_pkg::OP_COMPARE_REGS, cse_pkg::OP_COMPARE_REGS_WITH_CARRY,
    cse_pkg::OP_COMPARE_REG_IMMEDIATE}) |=> busy_then_idle_1 ##0 $stable(opa_reg))
    else $error("compare not one cycle or result written");

  AST_CMP_CARRY: assert property ( // RQ1
    commit && cmd_reg.op == cse_pkg::OP_COMPARE_REGS |=>
    flags_reg[`CSE_F_C] == ($past(opa_reg) < $past(opb_reg)))
    else $error("compare carry wrong");

  AST_SKIP_NONE: assert property ( // RQ2
    commit && is_skip(cmd_reg.op) && !cond_now |=> pc_reg == $past(pc_reg) + 16'h0001)
    else $error("untaken skip moved pc wrongly");

  AST_SKIP_LONG: assert property ( // RQ3
    go_cmd && is_skip(cmd_new.op) && cmd_new.two_word && cond_now_new
    |=> busy [*3] ##1 !busy)
    else $error("skip over two-word not three cycles");

  AST_BRANCH_TAKEN: assert property ( // RQ4
    commit && is_branch(cmd_reg.op) && cond_now |=>
    pc_reg == $past(pc_reg) + {{9{$past(cmd_reg.k[6])}}, $past(cmd_reg.k)} + 16'h0001
    && flags_reg == $past(flags_reg))
    else $error("taken branch target or flags wrong");

  AST_BRANCH_TIMING: assert property ( // RQ5
    go_cmd && cmd_new.op == cse_pkg::OP_BRANCH_IF_EQUAL && flags_reg[`CSE_F_Z]
    |=> busy_then_idle_2)
    else $error("taken equal branch not two cycles");

  AST_IO_SET: assert property ( // RQ13
    go_cmd && cmd_new.op == cse_pkg::OP_IO_BIT_SET_OP |=> busy_then_idle_2 ##0
    io_reg[$past(cmd_reg.sel)] && flags_reg == $past(flags_reg, 3))
    else $error("io bit set wrong");

  AST_SHIFT_FLAGS: assert property ( // RQ14
    commit && cmd_reg.op == cse_pkg::OP_LOGICAL_RIGHT_SHIFT |=>
    !opa_reg[7] && !flags_reg[`CSE_F_N] && flags_reg[`CSE_F_Z] == (opa_reg == 8'h00))
    else $error("logical right shift wrong");

  AST_ROTATE: assert property ( // RQ15
    commit && cmd_reg.op == cse_pkg::OP_ROTATE_UP_THROUGH_CARRY |=>
    opa_reg[0] == $past(flags_reg[`CSE_F_C]) && flags_reg[`CSE_F_C] == $past(opa_reg[7]))
    else $error("rotate through carry wrong");

  AST_FORCE: assert property ( // RQ18
    commit && cmd_reg.op == cse_pkg::OP_FLAG_FORCE_ONE |=>
    (flags_reg ^ $past(flags_reg)) == ($past(flags_reg) ^ ($past(flags_reg)
    | (8'h01 << $past(cmd_reg.sel)))))
    else $error("flag force touched other flags");

endmodule

/* File: hw/cse_map.svh */
`ifndef CSE_MAP_SVH
`define CSE_MAP_SVH

// Register byte offsets
`define CSE_OFS_CMD 8'h00
`define CSE_OFS_OPA 8'h04
`define CSE_OFS_OPB 8'h08
`define CSE_OFS_FLAGS 8'h0C
`define CSE_OFS_PC 8'h10
`define CSE_OFS_IOREG 8'h14
`define CSE_OFS_STATUS 8'h18

// Reset values
`define CSE_RST_BYTE 8'h00
`define CSE_RST_PC 16'h0000
`define CSE_RST_CMD 17'h0_0000

// Command word field positions
`define CSE_CMD_OP_LSB 0
`define CSE_CMD_OP_MSB 5
`define CSE_CMD_SEL_LSB 6
`define CSE_CMD_SEL_MSB 8
`define CSE_CMD_K_LSB 9
`define CSE_CMD_K_MSB 15
`define CSE_CMD_TWO_WORD 16

// Status register field positions
`define CSE_STS_BUSY 0
`define CSE_STS_TAKEN 1
`define CSE_STS_CYC_LSB 2
`define CSE_STS_CYC_MSB 3

// Flag byte bit positions
`define CSE_F_C 0
`define CSE_F_Z 1
`define CSE_F_N 2
`define CSE_F_V 3
`define CSE_F_S 4
`define CSE_F_H 5
`define CSE_F_T 6
`define CSE_F_I 7

// Cycle counts
`define CSE_CYC_ONE 2'd1
`define CSE_CYC_TWO 2'd2
`define CSE_CYC_THREE 2'd3

`endif

/* File: hw/cse_pkg.sv */
package cse_pkg;

  typedef enum logic [5:0] {
    OP_NOP = 6'h00,
    OP_COMPARE_REGS = 6'h01,
    OP_COMPARE_REGS_WITH_CARRY = 6'h02,
    OP_COMPARE_REG_IMMEDIATE = 6'h03,
    OP_SKIP_IF_REG_BIT_CLEAR = 6'h04,
    OP_SKIP_IF_REG_BIT_SET = 6'h05,
    OP_SKIP_IF_IO_BIT_CLEAR = 6'h06,
    OP_SKIP_IF_IO_BIT_SET = 6'h07,
    OP_BRANCH_STATUS_BIT_SET = 6'h08,
    OP_BRANCH_STATUS_BIT_CLEAR = 6'h09,
    OP_BRANCH_IF_EQUAL = 6'h0A,
    OP_BRANCH_IF_NOT_EQUAL = 6'h0B,
    OP_BRANCH_UNSIGNED_GE = 6'h0C,
    OP_BRANCH_UNSIGNED_LT = 6'h0D,
    OP_BRANCH_IF_NEGATIVE = 6'h0E,
    OP_BRANCH_IF_POSITIVE = 6'h0F,
    OP_BRANCH_SIGNED_GE = 6'h10,
    OP_BRANCH_SIGNED_LT = 6'h11,
    OP_BRANCH_HALFCARRY_ONE = 6'h12,
    OP_BRANCH_HALFCARRY_ZERO = 6'h13,
    OP_BRANCH_TRANSFER_FLAG_ONE = 6'h14,
    OP_BRANCH_TRANSFER_FLAG_ZERO = 6'h15,
    OP_BRANCH_OVERFLOW_ONE = 6'h16,
    OP_BRANCH_OVERFLOW_ZERO = 6'h17,
    OP_BRANCH_IRQ_ON = 6'h18,
    OP_BRANCH_IRQ_OFF = 6'h19,
    OP_IO_BIT_SET_OP = 6'h1A,
    OP_IO_BIT_CLEAR_OP = 6'h1B,
    OP_LOGICAL_LEFT_SHIFT = 6'h1C,
    OP_LOGICAL_RIGHT_SHIFT = 6'h1D,
    OP_ROTATE_UP_THROUGH_CARRY = 6'h1E,
    OP_ROTATE_DOWN_THROUGH_CARRY = 6'h1F,
    OP_ARITHMETIC_RIGHT_SHIFT = 6'h20,
    OP_BIT_TO_TRANSFER_FLAG = 6'h21,
    OP_TRANSFER_FLAG_TO_BIT = 6'h22,
    OP_FLAG_FORCE_ONE = 6'h23,
    OP_FLAG_FORCE_ZERO = 6'h24
  } cse_op_e;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } cse_state_e;

  typedef struct packed {
    logic two_word;
    logic [6:0] k;
    logic [2:0] sel;
    cse_op_e op;
  } cse_cmd_s;

  typedef struct packed {
    logic [7:0] res;
    logic [7:0] flags;
    logic wr_rd;
  } cse_alu_out_s;

endpackage

/* File: hw/cse_alu.sv */
`timescale 1ns/1ps
`include "cse_map.svh"

module cse_alu (
  input wire cse_pkg::cse_cmd_s cmd,
  input wire logic [7:0] opa,
  input wire logic [7:0] opb,
  input wire logic [7:0] flags_in,
  output cse_pkg::cse_alu_out_s alu_out
);

  logic [7:0] diff;
  logic [7:0] sh;
  logic sh_c;
  logic cin;
  logic is_cmp;
  logic is_shift;

  always_comb begin
    alu_out.res = opa;
    alu_out.flags = flags_in;
    alu_out.wr_rd = 1'b0;
    is_cmp = 1'b0;
    is_shift = 1'b1;
    cin = 1'b0;
    sh = opa;
    sh_c = flags_in[`CSE_F_C];
    case (cmd.op)
      cse_pkg::OP_COMPARE_REGS, cse_pkg::OP_COMPARE_REG_IMMEDIATE: begin
        is_cmp = 1'b1;
        is_shift = 1'b0;
      end
      cse_pkg::OP_COMPARE_REGS_WITH_CARRY: begin
        is_cmp = 1'b1;
        is_shift = 1'b0;
        cin = flags_in[`CSE_F_C];
      end
      cse_pkg::OP_LOGICAL_LEFT_SHIFT: begin
        sh = {opa[6:0], 1'b0}; // RQ14
        sh_c = opa[7];
      end
      cse_pkg::OP_LOGICAL_RIGHT_SHIFT: begin
        sh = {1'b0, opa[7:1]}; // RQ14
        sh_c = opa[0];
      end
      cse_pkg::OP_ROTATE_UP_THROUGH_CARRY: begin
        sh = {opa[6:0], flags_in[`CSE_F_C]}; // RQ15
        sh_c = opa[7];
      end
      cse_pkg::OP_ROTATE_DOWN_THROUGH_CARRY: begin
        sh = {flags_in[`CSE_F_C], opa[7:1]}; // RQ15
        sh_c = opa[0];
      end
      cse_pkg::OP_ARITHMETIC_RIGHT_SHIFT: begin
        sh = {opa[7], opa[7:1]}; // RQ17
        sh_c = opa[0];
      end
      default: begin
        is_shift = 1'b0;
      end
    endcase
    diff = opa - opb - {7'h00, cin}; // RQ1
    if (is_cmp) begin
      // Result discarded, flags only
      alu_out.flags[`CSE_F_H] = (~opa[3] & opb[3]) | (opb[3] & diff[3]) | (diff[3] & ~opa[3]);
      alu_out.flags[`CSE_F_C] = (~opa[7] & opb[7]) | (opb[7] & diff[7]) | (diff[7] & ~opa[7]);
      alu_out.flags[`CSE_F_V] = (opa[7] & ~opb[7] & ~diff[7]) | (~opa[7] & opb[7] & diff[7]);
      alu_out.flags[`CSE_F_N] = diff[7];
      // Carry variant keeps zero only if it was already set
      alu_out.flags[`CSE_F_Z] = (diff == 8'h00) & (~cin_used(cmd.op) | flags_in[`CSE_F_Z]);
      alu_out.flags[`CSE_F_S] = diff[7] ^ alu_out.flags[`CSE_F_V]; // RQ1
    end
    if (is_shift) begin
      alu_out.res = sh;
      alu_out.wr_rd = 1'b1;
      alu_out.flags[`CSE_F_C] = sh_c;
      alu_out.flags[`CSE_F_Z] = (sh == 8'h00);
      alu_out.flags[`CSE_F_N] = sh[7];
      alu_out.flags[`CSE_F_V] = sh[7] ^ sh_c; // RQ14 RQ15 RQ17
      alu_out.flags[`CSE_F_S] = sh_c;
    end
    if (cmd.op == cse_pkg::OP_BIT_TO_TRANSFER_FLAG) begin
      alu_out.flags[`CSE_F_T] = opa[cmd.sel]; // RQ16
    end
    if (cmd.op == cse_pkg::OP_TRANSFER_FLAG_TO_BIT) begin
      alu_out.res[cmd.sel] = flags_in[`CSE_F_T]; // RQ16
      alu_out.wr_rd = 1'b1;
    end
    if (cmd.op == cse_pkg::OP_FLAG_FORCE_ONE) begin
      alu_out.flags[cmd.sel] = 1'b1; // RQ18
    end
    if (cmd.op == cse_pkg::OP_FLAG_FORCE_ZERO) begin
      alu_out.flags[cmd.sel] = 1'b0; // RQ18
    end
  end

  function automatic logic cin_used(input cse_pkg::cse_op_e op);
    cin_used = (op == cse_pkg::OP_COMPARE_REGS_WITH_CARRY);
  endfunction

endmodule

/* File: verif/cmp_skip_branch_bit_exec_tb.sv */
`timescale 1ns/1ps
`include "cse_map.svh"

module cmp_skip_branch_bit_exec_tb;
  localparam logic [15:0] PC0 = 16'h0040;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;
  logic [7:0] r_a;
  logic [7:0] r_f;
  logic [7:0] r_io;
  logic [15:0] r_pc;
  logic [3:0] r_st;

  cse_exec_core uut (
    .clk(clk),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: got %h, expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic exec(input cse_pkg::cse_op_e op, input logic [2:0] s, input logic [6:0] k,
                      input logic tw, input logic [7:0] a, input logic [7:0] b,
                      input logic [7:0] f, input logic [7:0] io);
    cse_pkg::cse_cmd_s c;
    c = '{two_word: tw, k: k, sel: s, op: op};
    apb(1'b1, `CSE_OFS_OPA, 32'(a));
    apb(1'b1, `CSE_OFS_OPB, 32'(b));
    apb(1'b1, `CSE_OFS_FLAGS, 32'(f));
    apb(1'b1, `CSE_OFS_PC, 32'(PC0));
    apb(1'b1, `CSE_OFS_IOREG, 32'(io));
    apb(1'b1, `CSE_OFS_CMD, 32'(c));
    do apb(1'b0, `CSE_OFS_STATUS, 32'h0000_0000); while (rd[`CSE_STS_BUSY] !== 1'b0);
    r_st = rd[3:0];
    apb(1'b0, `CSE_OFS_OPA, 32'h0000_0000);
    r_a = rd[7:0];
    apb(1'b0, `CSE_OFS_FLAGS, 32'h0000_0000);
    r_f = rd[7:0];
    apb(1'b0, `CSE_OFS_IOREG, 32'h0000_0000);
    r_io = rd[7:0];
    apb(1'b0, `CSE_OFS_PC, 32'h0000_0000);
    r_pc = rd[15:0];
  endtask

  task automatic verify(input logic [7:0] ea, input logic [7:0] ef, input logic [7:0] ei,
                        input logic [15:0] epc, input logic [1:0] ec);
    chk(32'(r_a), 32'(ea), "operand");
    chk(32'(r_f), 32'(ef), "flags");
    chk(32'(r_io), 32'(ei), "io register");
    chk(32'(r_pc), 32'(epc), "pc");
    chk(32'(r_st[3:2]), 32'(ec), "cycles");
  endtask

  function automatic logic [7:0] cmp_f(input logic [7:0] a, input logic [7:0] b,
                                       input logic [7:0] f, input logic cin, input logic zk);
    logic [7:0] r;
    logic [7:0] o;
    r = a - b - 8'(cin);
    o = f;
    o[`CSE_F_N] = r[7];
    o[`CSE_F_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    o[`CSE_F_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    o[`CSE_F_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    o[`CSE_F_Z] = (r == 8'h00) & (zk | f[`CSE_F_Z]);
    o[`CSE_F_S] = r[7] ^ o[`CSE_F_V];
    return o;
  endfunction

  function automatic logic [15:0] sh(input cse_pkg::cse_op_e op, input logic [7:0] a,
                                     input logic [7:0] f);
    logic [7:0] r;
    logic [7:0] o;
    logic c;
    c = a[0];
    case (op)
      cse_pkg::OP_LOGICAL_LEFT_SHIFT: r = {a[6:0], 1'b0};
      cse_pkg::OP_LOGICAL_RIGHT_SHIFT: r = {1'b0, a[7:1]};
      cse_pkg::OP_ROTATE_UP_THROUGH_CARRY: r = {a[6:0], f[`CSE_F_C]};
      cse_pkg::OP_ROTATE_DOWN_THROUGH_CARRY: r = {f[`CSE_F_C], a[7:1]};
      default: r = {a[7], a[7:1]};
    endcase
    if (op == cse_pkg::OP_LOGICAL_LEFT_SHIFT || op == cse_pkg::OP_ROTATE_UP_THROUGH_CARRY) begin
      c = a[7];
    end
    o = f;
    o[`CSE_F_C] = c;
    o[`CSE_F_Z] = (r == 8'h00);
    o[`CSE_F_N] = r[7];
    o[`CSE_F_V] = r[7] ^ c;
    o[`CSE_F_S] = c;
    return {r, o};
  endfunction

  // Condition vector, bit 0 belongs to the first branch code
  function automatic logic bcond(input int o, input logic [2:0] s, input logic [7:0] f);
    logic [17:0] t;
    logic nv;
    nv = f[`CSE_F_N] ^ f[`CSE_F_V];
    t = {~f[`CSE_F_I], f[`CSE_F_I], ~f[`CSE_F_V], f[`CSE_F_V], ~f[`CSE_F_T], f[`CSE_F_T],
         ~f[`CSE_F_H], f[`CSE_F_H], nv, ~nv, ~f[`CSE_F_N], f[`CSE_F_N], f[`CSE_F_C],
         ~f[`CSE_F_C], ~f[`CSE_F_Z], f[`CSE_F_Z], ~f[s], f[s]};
    return t[o - 8];
  endfunction

  initial begin
    logic [7:0] va [5] = '{8'h10, 8'h00, 8'h80, 8'h7F, 8'h18};
    logic [7:0] vb [5] = '{8'h10, 8'h01, 8'h01, 8'hFF, 8'h09};
    logic [7:0] fp [5] = '{8'h03, 8'h00, 8'hC1, 8'h02, 8'h20};
    logic [7:0] bf [4] = '{8'h00, 8'hFF, 8'h04, 8'h08};
    logic [7:0] v;
    logic [7:0] f;
    logic [6:0] k;
    logic [15:0] e;
    logic tk;
    logic tw;
    cse_pkg::cse_op_e op;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, `CSE_OFS_PC, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "pc after reset");
    for (int o = 1; o <= 3; o++) begin
      op = cse_pkg::cse_op_e'(o[5:0]);
      for (int i = 0; i < 5; i++) begin
        exec(op, 3'd0, 7'h00, 1'b0, va[i], vb[i], fp[i], 8'h00);
        f = cmp_f(va[i], vb[i], fp[i], (o == 2) & fp[i][`CSE_F_C], o != 2);
        verify(va[i], f, 8'h00, PC0 + 16'h0001, `CSE_CYC_ONE);
      end
    end
    for (int o = 4; o <= 7; o++) begin
      op = cse_pkg::cse_op_e'(o[5:0]);
      for (int s = 0; s < 8; s++) begin
        v = (o < 6) ? 8'hA5 : 8'h5A;
        tw = s[1];
        tk = (8'hA5 >> s) & 8'h01 ? o[0] : ~o[0];
        exec(op, 3'(s), 7'h00, tw, v, v, 8'h5A, ~v);
        verify(v, 8'h5A, ~v, PC0 + 16'h0001 + (tk ? 16'h0001 + 16'(tw) : 16'h0000),
               tk ? 2'd2 + 2'(tw) : `CSE_CYC_ONE);
        chk(32'(r_st[`CSE_STS_TAKEN]), 32'(tk), "skip taken");
      end
    end
    for (int o = 8; o <= 25; o++) begin
      op = cse_pkg::cse_op_e'(o[5:0]);
      for (int j = 0; j < 4; j++) begin
        k = j[0] ? 7'h40 : 7'h3F;
        tk = bcond(o, 3'(o + j), bf[j]);
        exec(op, 3'(o + j), k, 1'b0, 8'h00, 8'h00, bf[j], 8'h00);
        e = PC0 + 16'h0001 + (tk ? {{9{k[6]}}, k} : 16'h0000);
        verify(8'h00, bf[j], 8'h00, e, tk ? `CSE_CYC_TWO : `CSE_CYC_ONE);
        chk(32'(r_st[`CSE_STS_TAKEN]), 32'(tk), "branch taken");
      end
    end
    for (int o = 26; o <= 27; o++) begin
      op = cse_pkg::cse_op_e'(o[5:0]);
      for (int s = 0; s < 8; s++) begin
        v = (o == 26) ? (8'h5A | (8'h01 << s)) : (8'h5A & ~(8'h01 << s));
        exec(op, 3'(s), 7'h00, 1'b0, 8'h00, 8'h00, 8'hA5, 8'h5A);
        verify(8'h00, 8'hA5, v, PC0 + 16'h0001, `CSE_CYC_TWO);
      end
    end
    for (int o = 28; o <= 32; o++) begin
      op = cse_pkg::cse_op_e'(o[5:0]);
      for (int i = 0; i < 4; i++) begin
        e = sh(op, va[i + 1] ^ 8'h01, fp[i]);
        exec(op, 3'd0, 7'h00, 1'b0, va[i + 1] ^ 8'h01, 8'h00, fp[i], 8'h00);
        verify(e[15:8], e[7:0], 8'h00, PC0 + 16'h0001, `CSE_CYC_ONE);
      end
    end
    for (int s = 0; s < 8; s++) begin
      f = s[0] ? 8'hFF : 8'h00;
      v = f;
      v[`CSE_F_T] = (8'h96 >> s) & 8'h01 ? 1'b1 : 1'b0;
      exec(cse_pkg::OP_BIT_TO_TRANSFER_FLAG, 3'(s), 7'h00, 1'b0, 8'h96, 8'h96, f, 8'h00);
      verify(8'h96, v, 8'h00, PC0 + 16'h0001, `CSE_CYC_ONE);
      v = s[1] ? (8'h96 | (8'h01 << s)) : (8'h96 & ~(8'h01 << s));
      f = s[1] ? 8'h40 : 8'hBF;
      exec(cse_pkg::OP_TRANSFER_FLAG_TO_BIT, 3'(s), 7'h00, 1'b0, 8'h96, 8'h96, f, 8'h00);
      verify(v, f, 8'h00, PC0 + 16'h0001, `CSE_CYC_ONE);
    end
    for (int o = 35; o <= 36; o++) begin
      op = cse_pkg::cse_op_e'(o[5:0]);
      for (int s = 0; s < 8; s++) begin
        f = (o == 35) ? 8'h00 : 8'hFF;
        exec(op, 3'(s), 7'h00, 1'b0, 8'h00, 8'h00, f, 8'h00);
        verify(8'h00, f ^ (8'h01 << s), 8'h00, PC0 + 16'h0001, `CSE_CYC_ONE);
      end
    end
    exec(cse_pkg::OP_NOP, 3'd5, 7'h11, 1'b1, 8'h3C, 8'hC3, 8'h96, 8'h69);
    verify(8'h3C, 8'h96, 8'h69, PC0 + 16'h0001, `CSE_CYC_ONE);
    // Write right behind a command lands while busy and is refused
    apb(1'b1, `CSE_OFS_CMD, 32'(cse_pkg::OP_IO_BIT_SET_OP));
    apb(1'b1, `CSE_OFS_OPA, 32'h0000_00EE);
    chk(32'(err), 32'h0000_0001, "write while busy error");
    apb(1'b0, `CSE_OFS_OPA, 32'h0000_0000);
    chk(rd, 32'h0000_003C, "write while busy ignored");
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001, "unmapped read error");
    chk(rd, 32'h0000_0000, "unmapped read data");
    apb(1'b1, `CSE_OFS_STATUS, 32'h0000_00FF);
    chk(32'(err), 32'h0000_0001, "status write error");
    report_and_stop();
  end
endmodule
